/* File: hdl/tcoc_pkg.sv */
// package: constants and types for the two-channel timer capture and output control
// Operation
// - capture trigger pulse must last longer than two count clock cycles
// - level set and level reset bits always read back as zero
// - one-shot trigger bit clears itself and reads as zero
// - internal oscillator count clock gives no guaranteed counter operation
// - inputs sampled by internal oscillator clock; external clock then unguaranteed
// - counter runs when operating-mode bits are not 0,0; 0,0 stops it
package tcoc_pkg;
  localparam int          NUM_CH        = 2;
  localparam int          CNT_W         = 16;
  localparam int          PRE_W         = 2;
  localparam int          STABLE_CNT    = 2;
  localparam logic [1:0]  MODE_STOP     = 2'h0;
  localparam logic [1:0]  MODE_CLR_MATCH = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  // prescaler select: divide by 2^(2*sel)
  localparam logic [7:0]  DIV_STEP      = 8'h02;

  typedef struct packed {
    logic capture_zero;   // compare register zero used as capture register
    logic rising_edge;    // capture on rising edge, else falling
  } tcoc_capcmp_t;

  typedef struct packed {
    logic match_one_out_enable;
    logic match_zero_out_enable;
    logic oneshot_enable;
    logic timer_out_enable;
  } tcoc_outctl_t;

  typedef struct packed {
    logic level_set;
    logic level_reset;
    logic oneshot_trigger;
  } tcoc_outcmd_t;
endpackage : tcoc_pkg

/* File: hdl/tcoc_top.sv */
// module: two-channel capture/compare and output control for a 16-bit timer
`timescale 1ns/10ps
`default_nettype none
module tcoc_top #(
  parameter int NCH = tcoc_pkg::NUM_CH
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [NCH-1:0][1:0]                  mode_ctrl,
  input  wire logic [NCH-1:0][tcoc_pkg::PRE_W-1:0]  prescale_sel,
  input  wire tcoc_pkg::tcoc_capcmp_t [NCH-1:0]     capcmp_ctrl,
  input  wire tcoc_pkg::tcoc_outctl_t [NCH-1:0]     out_ctrl,
  input  wire logic [NCH-1:0]                       out_cmd_wr,
  input  wire tcoc_pkg::tcoc_outcmd_t [NCH-1:0]     out_cmd,
  input  wire logic [NCH-1:0][tcoc_pkg::CNT_W-1:0]  compare_reg_one,
  input  wire logic [NCH-1:0]                       ext_input_a,
  output logic [NCH-1:0][tcoc_pkg::CNT_W-1:0]       counter,
  output logic [NCH-1:0][tcoc_pkg::CNT_W-1:0]       compare_reg_zero,
  output logic [NCH-1:0]                            capture_pulse,
  output logic [NCH-1:0]                            timer_out,
  output tcoc_pkg::tcoc_outcmd_t [NCH-1:0]          out_cmd_rd
);
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic        sync1;
      logic        sync2;
      logic [7:0]  pdiv;
      logic        tick;
      logic        stable_lvl;
      logic [1:0]  stable_cnt;
      logic        run;
      logic        trig_pend;
      logic        match_one;
      logic        match_zero;
      logic        next_stable;

      assign run = (mode_ctrl[g] != tcoc_pkg::MODE_STOP);

      // two-flop synchroniser on the external input, sampled by the one clock
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
        end else begin
          sync1 <= ext_input_a[g];
          sync2 <= sync1;
        end
      end

      // prescaler divider: count clock enable pulse from the one clock
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pdiv <= 8'h00;
          tick <= 1'b0;
        end else begin
          pdiv <= pdiv + 8'h01;
          tick <= ((pdiv & ((8'h01 << (tcoc_pkg::DIV_STEP * prescale_sel[g])) - 8'h01))
                   == 8'h00);
        end
      end

      // level must hold for two count clocks before edge is accepted
      assign next_stable = (stable_cnt >= 2'(tcoc_pkg::STABLE_CNT - 1)) ? sync2 : stable_lvl;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stable_cnt <= 2'h0;
          stable_lvl <= 1'b0;
          capture_pulse[g] <= 1'b0;
        end else begin
          capture_pulse[g] <= 1'b0;
          if (tick) begin
            if (sync2 == stable_lvl) begin
              stable_cnt <= 2'h0;
            end else if (stable_cnt >= 2'(tcoc_pkg::STABLE_CNT - 1)) begin
              stable_cnt <= 2'h0;
              stable_lvl <= sync2;
              capture_pulse[g] <= run && capcmp_ctrl[g].capture_zero &&
                                  (next_stable == capcmp_ctrl[g].rising_edge);
            end else begin
              stable_cnt <= stable_cnt + 2'h1;
            end
          end
        end
      end

      // counter and capture into compare register zero
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          counter[g] <= tcoc_pkg::CNT_ZERO;
          compare_reg_zero[g] <= tcoc_pkg::CNT_ZERO;
        end else if (!run) begin
          counter[g] <= tcoc_pkg::CNT_ZERO;
        end else begin
          if (capture_pulse[g]) begin
            compare_reg_zero[g] <= counter[g];
          end
          if (tick) begin
            if (trig_pend || (mode_ctrl[g] == tcoc_pkg::MODE_CLR_MATCH && match_zero)) begin
              counter[g] <= tcoc_pkg::CNT_ZERO;
            end else begin
              counter[g] <= counter[g] + tcoc_pkg::CNT_ONE;
            end
          end
        end
      end

      assign match_one  = (counter[g] == compare_reg_one[g]);
      assign match_zero = (counter[g] == compare_reg_zero[g]);

      // one-shot trigger is a pulse held until the next count tick
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          trig_pend <= 1'b0;
        end else if (out_cmd_wr[g] && out_cmd[g].oneshot_trigger &&
                     out_ctrl[g].oneshot_enable) begin
          trig_pend <= 1'b1;
        end else if (tick) begin
          trig_pend <= 1'b0;
        end
      end

      // output flip-flop: level set/reset commands and match toggles
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          timer_out[g] <= 1'b0;
        end else if (!out_ctrl[g].timer_out_enable) begin
          timer_out[g] <= 1'b0;
        end else if (out_cmd_wr[g] && out_cmd[g].level_set) begin
          timer_out[g] <= 1'b1;
        end else if (out_cmd_wr[g] && out_cmd[g].level_reset) begin
          timer_out[g] <= 1'b0;
        end else if (run && tick && ((out_ctrl[g].match_one_out_enable && match_one) ||
                                     (out_ctrl[g].match_zero_out_enable && match_zero))) begin
          timer_out[g] <= ~timer_out[g];
        end
      end

      // command bits never read back as set
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          out_cmd_rd[g] <= '0;
        end else begin
          out_cmd_rd[g] <= '0;
        end
      end
    end
  endgenerate
endmodule : tcoc_top
`default_nettype wire

/* File: tb/tcoc_checker.sv */
// checker: port assertions for the timer capture and output control
`timescale 1ns/10ps
`default_nettype none
module tcoc_checker #(
  parameter int NCH = 2
) (
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire logic [NCH-1:0][1:0]              mode_ctrl,
  input wire logic [NCH-1:0][1:0]              prescale_sel,
  input wire tcoc_pkg::tcoc_capcmp_t [NCH-1:0] capcmp_ctrl,
  input wire tcoc_pkg::tcoc_outctl_t [NCH-1:0] out_ctrl,
  input wire logic [NCH-1:0]                   out_cmd_wr,
  input wire tcoc_pkg::tcoc_outcmd_t [NCH-1:0] out_cmd,
  input wire logic [NCH-1:0][15:0]             counter,
  input wire logic [NCH-1:0][15:0]             compare_reg_zero,
  input wire logic [NCH-1:0]                   capture_pulse,
  input wire logic [NCH-1:0]                   timer_out,
  input wire tcoc_pkg::tcoc_outcmd_t [NCH-1:0] out_cmd_rd
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rd_zero: assert property (out_cmd_rd == '0)
    else $error("readback not zero");
  chk_stop_clear: assert property (mode_ctrl[0] == 2'h0 |=> counter[0] == 16'h0000)
    else $error("counter not cleared");
  chk_run_count: assert property ((mode_ctrl[0] == 2'h1 && prescale_sel[0] == 2'h0) [*2]
    |=> counter[0] == $past(counter[0]) + 16'h0001) else $error("counter not counting");
  chk_pulse_one: assert property (capture_pulse[0] |=> !capture_pulse[0])
    else $error("capture pulse too long");
  chk_cap_load: assert property ($changed(compare_reg_zero[0]) |-> $past(capture_pulse[0]))
    else $error("capture value without pulse");
  chk_no_cap: assert property (!capcmp_ctrl[1].capture_zero [*4] |-> !capture_pulse[1])
    else $error("capture while disabled");
  chk_out_off: assert property (!out_ctrl[0].timer_out_enable [*2] |-> !timer_out[0])
    else $error("output active while disabled");
  chk_lvl_set: assert property (out_cmd_wr[0] && out_cmd[0].level_set
    && out_ctrl[0].timer_out_enable |=> timer_out[0]) else $error("level set missed");
  chk_lvl_rst: assert property (out_cmd_wr[1] && out_cmd[1] == 3'h2
    && out_ctrl[1].timer_out_enable |=> !timer_out[1]) else $error("level reset missed");
endmodule : tcoc_checker
bind tcoc_top tcoc_checker #(.NCH(NCH)) u_chk (.clk(clk), .rst_n(rst_n), .mode_ctrl(mode_ctrl),
  .prescale_sel(prescale_sel), .capcmp_ctrl(capcmp_ctrl), .out_ctrl(out_ctrl),
  .out_cmd_wr(out_cmd_wr), .out_cmd(out_cmd), .counter(counter),
  .compare_reg_zero(compare_reg_zero), .capture_pulse(capture_pulse),
  .timer_out(timer_out), .out_cmd_rd(out_cmd_rd));
`default_nettype wire

/* File: tb/tcoc_pin_model.sv */
// partner: external input pins giving pulses of commanded width
`timescale 1ns/10ps
`default_nettype none
module tcoc_pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] go,
  input  wire logic [7:0] len,
  output var logic  [1:0] pin
);
  logic [1:0][7:0] cnt = '0;
  initial pin = '0;
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      pin[i] <= go[i] || cnt[i] > 8'h01;
      cnt[i] <= go[i] ? len : cnt[i] - {7'h00, cnt[i] != 8'h00};
    end
  end
endmodule : tcoc_pin_model
`default_nettype wire

/* File: tb/timer16_capture_output_control_bench.sv */
// bench: timer capture and output control with queued expectations
`timescale 1ns/10ps
`default_nettype none
module timer16_capture_output_control_bench;
  logic                         clk = 0, rst_n = 0, prev_t = 0;
  logic [1:0][1:0]              mode_ctrl = '0, prescale_sel = '0;
  tcoc_pkg::tcoc_capcmp_t [1:0] capcmp_ctrl = '0;
  tcoc_pkg::tcoc_outctl_t [1:0] out_ctrl = '0;
  tcoc_pkg::tcoc_outcmd_t [1:0] out_cmd = '0, out_cmd_rd;
  logic [1:0]                   out_cmd_wr = '0, go = '0, timer_out, capture_pulse, ext_input_a;
  logic [1:0][15:0]             compare_reg_one = '0, counter, crz;
  logic [15:0]                  cap_v = '0;
  logic                         cap_due = 0;
  logic [7:0]                   len = '0;
  logic [31:0]                  rs = 32'h0066;
  int                           err_count = 0, checks = 0, cyc = 0;
  logic                         q_t[$], q_c[$];
  tcoc_top i_dut (.clk(clk), .rst_n(rst_n), .mode_ctrl(mode_ctrl), .prescale_sel(prescale_sel),
    .capcmp_ctrl(capcmp_ctrl), .out_ctrl(out_ctrl), .out_cmd_wr(out_cmd_wr), .out_cmd(out_cmd),
    .compare_reg_one(compare_reg_one), .ext_input_a(ext_input_a), .counter(counter),
    .compare_reg_zero(crz), .capture_pulse(capture_pulse), .timer_out(timer_out),
    .out_cmd_rd(out_cmd_rd));
  tcoc_pin_model i_pin (.clk(clk), .go(go), .len(len), .pin(ext_input_a));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [2:0] c);
    out_cmd = {2{c}};
    out_cmd_wr = 2'h3;
    @(negedge clk);
    out_cmd_wr = 2'h0;
    @(negedge clk);
  endtask : wr
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    err_count++;
    conclude();
  end
  always @(posedge clk) begin
    #1;
    if (timer_out[0] !== prev_t) begin
      prev_t = timer_out[0];
      cmp(timer_out[0], q_t.size() ? q_t.pop_front() : ~timer_out[0]);
    end
    if (capture_pulse[0] === 1'b1) cmp(q_c.size() ? q_c.pop_front() : 1'b0, 1'b1);
    if (capture_pulse[1] !== 1'b0) cmp(capture_pulse[1], 1'b0);
    if (cap_due) cmp(crz[0], cap_v);
    cap_due = (capture_pulse[0] === 1'b1);
    cap_v = counter[0];
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    capcmp_ctrl = 4'h3;
    out_ctrl = 8'h33;
    @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      q_t.push_back(!i[0]);
      wr(i[0] ? 3'h2 : (i[1] ? 3'h6 : 3'h4));
      wr(3'h1);
      cmp(out_cmd_rd, 16'h0000);
    end
    mode_ctrl = 4'h5;
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      compare_reg_one = rs;
      len = i[0] ? 8'h01 : 8'h04 + rs[10:8];
      if (!i[0]) q_c.push_back(1'b1);
      go = 2'h3;
      @(negedge clk);
      go = 2'h0;
      repeat (20) @(negedge clk);
    end
    out_cmd = 6'h08;
    out_cmd_wr = 2'h2;
    @(negedge clk);
    out_cmd_wr = 2'h0;
    @(negedge clk);
    cmp(counter[1], 16'h0000);
    mode_ctrl = 4'h0;
    repeat (2) @(negedge clk);
    cmp(counter[0], 16'h0000);
    cmp(q_t.size() + q_c.size(), 16'h0000);
    conclude();
  end
endmodule : timer16_capture_output_control_bench
`default_nettype wire
